// ### core/mlic_regs.vh
`ifndef MLIC_REGS_VH
`define MLIC_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MLIC_OFF_ENABLE    8'h00
`define MLIC_OFF_LEVEL_LO  8'h04
`define MLIC_OFF_LEVEL_HI  8'h08
`define MLIC_OFF_CTRL      8'h0c
`define MLIC_OFF_STATUS    8'h10
`define MLIC_OFF_RRPTR     8'h14
`define MLIC_OFF_PENDING   8'h18

// ----------------------------------------
// control and status fields
// ----------------------------------------
`define MLIC_CTRL_LOEN     0
`define MLIC_CTRL_MEDEN    1
`define MLIC_CTRL_HIEN     2
`define MLIC_CTRL_RREN     6
`define MLIC_CTRL_IVSEL    7
`define MLIC_CTRL_RST      8'h00
`define MLIC_STAT_NMI      7

// ----------------------------------------
// level codes
// ----------------------------------------
`define MLIC_LVL_OFF       2'h0
`define MLIC_LVL_LOW       2'h1
`define MLIC_LVL_MED       2'h2
`define MLIC_LVL_HIGH      2'h3

// ----------------------------------------
// word addresses of vectors and bases
// ----------------------------------------
`define MLIC_RESET_VEC     16'h0000
`define MLIC_XTAL_FAIL_VEC 16'h0002
`define MLIC_PIN_C_BASE    16'h0004
`define MLIC_PIN_R_BASE    16'h0008
`define MLIC_DMA_BASE      16'h000c
`define MLIC_RTC_BASE      16'h0014
`define MLIC_TWO_WIRE_C    16'h0018
`define MLIC_CNT_C1_BASE   16'h001c
`define MLIC_CNT_C2_BASE   16'h0028
`define MLIC_SPI_C_VEC     16'h0030
`define MLIC_SER_C_BASE    16'h0032
`define MLIC_USB_BASE      16'h003e
`define MLIC_DISPLAY_BASE  16'h0046
`define MLIC_CIPHER_VEC    16'h0048
`define MLIC_NVCTRL_BASE   16'h004a
`define MLIC_PIN_B_BASE    16'h004e
`define MLIC_COMP_B_BASE   16'h0052
`define MLIC_CONV_B_BASE   16'h0058
`define MLIC_PIN_D_BASE    16'h0060
`define MLIC_PIN_G_BASE    16'h0064
`define MLIC_CNT_E1_BASE   16'h0074
`define MLIC_SER_E_BASE    16'h008a
`define MLIC_PIN_A_BASE    16'h0096
`define MLIC_COMP_A_BASE   16'h009a
`define MLIC_CONV_A_BASE   16'h00a0
`define MLIC_SLOT_OFS      16'h0002

`endif

// ### core/mlic_first_set.v
// lowest set index wins; lowest index equals lowest vector
module mlic_first_set #(
    parameter N  = 32,
    parameter IW = 5
) (
    input  wire [N-1:0]  req,
    output reg           found,
    output reg  [IW-1:0] idx
);
    integer i;
    always @* begin
        found = 1'b0;
        idx   = {IW{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = i[IW-1:0];
            end
        end
    end
endmodule

// ### core/mlic_level_track.v
// bit 0 low, 1 medium, 2 high, 3 non-maskable
module mlic_level_track (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       set_en,
    input  wire [3:0] set_onehot,
    input  wire       ret,
    output reg  [3:0] active
);
    reg [3:0] next_active;

    always @* begin
        next_active = active;
        // a return always belongs to the most urgent running handler
        if (ret) begin
            if (active[3])
                next_active[3] = 1'b0;
            else if (active[2])
                next_active[2] = 1'b0;
            else if (active[1])
                next_active[1] = 1'b0;
            else
                next_active[0] = 1'b0;
        end
        if (set_en)
            next_active = next_active | set_onehot;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            active <= 4'h0;
        else
            active <= next_active;
    end
endmodule

// ### core/mlic_top.v
// Function
// - a source requests only while its condition holds, enabled and given a level
// - on acknowledge the program counter is loaded with the vector
// - low, medium or high per source; level first, vector second
// - medium requests preempt a running low handler
// - high requests preempt running medium or low handlers
// - equal level: lowest vector address wins
// - optional round robin for low level keeps service bounded
// - non-maskable class ignores level masking
// - crystal failure is non-maskable at word 0x002
// - vector is peripheral base plus interrupt offset
// - vectors are program word addresses
// - serial periph c at 0x030, cipher unit at 0x048
// - pin groups c, r, d at 0x004, 0x008, 0x060
// - pin groups b, g, a at 0x04e, 0x064, 0x096
// - dma base 0x00c, real-time counter base 0x014
// - counters at 0x01c, 0x028 and 0x074
// - two-wire 0x018, serial ports 0x032 and 0x08a
// - usb 0x03e, display 0x046, nonvolatile control 0x04a
// - comparator b 0x052, converter b 0x058, converter a 0x0a0
// - comparator a group at 0x09a
// - after reset fetch from word 0 or boot section start
`include "mlic_regs.vh"

module mlic_top #(
    parameter N         = 26,
    parameter IW        = 5,
    parameter VW        = 16,
    parameter BOOT_BASE = 16'h0800
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire [N-1:0]  irq_in,
    input  wire          crystal_fail,
    input  wire          boot_reset_sel,
    input  wire          cpu_ack,
    input  wire          cpu_reti,
    output reg           intr_req,
    output reg  [1:0]    intr_level,
    output reg           intr_nmi,
    output reg           pc_load,
    output reg  [VW-1:0] pc_value,
    output reg  [N-1:0]  src_ack
);

    // ----------------------------------------
    // vector table
    // ----------------------------------------
    // index order follows vector order so lowest index means lowest address
    function [15:0] src_vector;
        input [IW-1:0] s;
        begin
            case (s)
                5'd0:  src_vector = `MLIC_PIN_C_BASE;
                5'd1:  src_vector = `MLIC_PIN_C_BASE + `MLIC_SLOT_OFS;
                5'd2:  src_vector = `MLIC_PIN_R_BASE;
                5'd3:  src_vector = `MLIC_DMA_BASE;
                5'd4:  src_vector = `MLIC_RTC_BASE;
                5'd5:  src_vector = `MLIC_RTC_BASE + `MLIC_SLOT_OFS;
                5'd6:  src_vector = `MLIC_TWO_WIRE_C;
                5'd7:  src_vector = `MLIC_CNT_C1_BASE;
                5'd8:  src_vector = `MLIC_CNT_C2_BASE;
                5'd9:  src_vector = `MLIC_SPI_C_VEC;
                5'd10: src_vector = `MLIC_SER_C_BASE;
                5'd11: src_vector = `MLIC_USB_BASE;
                5'd12: src_vector = `MLIC_DISPLAY_BASE;
                5'd13: src_vector = `MLIC_CIPHER_VEC;
                5'd14: src_vector = `MLIC_NVCTRL_BASE;
                5'd15: src_vector = `MLIC_PIN_B_BASE;
                5'd16: src_vector = `MLIC_COMP_B_BASE;
                5'd17: src_vector = `MLIC_CONV_B_BASE;
                5'd18: src_vector = `MLIC_PIN_D_BASE;
                5'd19: src_vector = `MLIC_PIN_G_BASE;
                5'd20: src_vector = `MLIC_CNT_E1_BASE;
                5'd21: src_vector = `MLIC_SER_E_BASE;
                5'd22: src_vector = `MLIC_PIN_A_BASE;
                5'd23: src_vector = `MLIC_COMP_A_BASE;
                5'd24: src_vector = `MLIC_CONV_A_BASE;
                5'd25: src_vector = `MLIC_CONV_A_BASE + `MLIC_SLOT_OFS;
                default: src_vector = `MLIC_RESET_VEC;
            endcase
        end
    endfunction

    // word address, optionally moved into the boot section
    function [VW-1:0] place;
        input [15:0] w;
        input        boot;
        begin
            place = boot ? (w[VW-1:0] + BOOT_BASE[VW-1:0]) : w[VW-1:0];
        end
    endfunction

    // one source at one level, behind its own and the level's enable
    function level_pend;
        input       req;
        input       src_en;
        input       lvl_en;
        input [1:0] src_lvl;
        input [1:0] want;
        begin
            level_pend = req & src_en & lvl_en & (src_lvl == want);
        end
    endfunction

    // status view: low, medium, high in the low bits, non-maskable on top
    function [31:0] status_word;
        input [3:0] act;
        begin
            status_word                 = 32'h0000_0000;
            status_word[0]              = act[0];
            status_word[1]              = act[1];
            status_word[2]              = act[2];
            status_word[`MLIC_STAT_NMI] = act[3];
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [31:0]   en;
    reg  [63:0]   lvl;
    reg  [7:0]    ctrl;
    reg  [IW-1:0] rr_ptr;
    reg           rst_fetch;
    reg  [IW-1:0] win_idx;

    wire [3:0]    active;
    wire          setup_ph;
    wire          wr_fire;
    reg  [N-1:0]  pend_lo;
    reg  [N-1:0]  pend_med;
    reg  [N-1:0]  pend_hi;
    reg  [N-1:0]  lo_above;
    wire [IW-1:0] idx_hi;
    wire [IW-1:0] idx_med;
    wire [IW-1:0] idx_lo;
    wire [IW-1:0] idx_rr;
    wire          f_hi;
    wire          f_med;
    wire          f_lo;
    wire          f_rr;
    wire          take;
    reg           next_req;
    reg  [1:0]    next_level;
    reg           next_nmi;
    reg  [IW-1:0] next_idx;
    reg  [31:0]   rd_data;
    reg           rd_err;
    integer       k;

    assign setup_ph = psel & ~penable;
    assign wr_fire  = psel & penable & pready & pwrite;
    assign take     = cpu_ack & intr_req;

    // ----------------------------------------
    // pending requests per level
    // ----------------------------------------
    always @* begin
        for (k = 0; k < N; k = k + 1) begin
            pend_lo[k]  = level_pend(irq_in[k], en[k], ctrl[`MLIC_CTRL_LOEN],
                                     lvl[2*k +: 2], `MLIC_LVL_LOW);
            pend_med[k] = level_pend(irq_in[k], en[k], ctrl[`MLIC_CTRL_MEDEN],
                                     lvl[2*k +: 2], `MLIC_LVL_MED);
            pend_hi[k]  = level_pend(irq_in[k], en[k], ctrl[`MLIC_CTRL_HIEN],
                                     lvl[2*k +: 2], `MLIC_LVL_HIGH);
            // round robin looks past the last served low source first
            lo_above[k] = pend_lo[k] & (k > rr_ptr);
        end
    end

    mlic_first_set #(.N(N), .IW(IW)) u_hi (
        .req   (pend_hi),
        .found (f_hi),
        .idx   (idx_hi)
    );

    mlic_first_set #(.N(N), .IW(IW)) u_med (
        .req   (pend_med),
        .found (f_med),
        .idx   (idx_med)
    );

    mlic_first_set #(.N(N), .IW(IW)) u_lo (
        .req   (pend_lo),
        .found (f_lo),
        .idx   (idx_lo)
    );

    mlic_first_set #(.N(N), .IW(IW)) u_rr (
        .req   (lo_above),
        .found (f_rr),
        .idx   (idx_rr)
    );

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    always @* begin
        next_req   = 1'b0;
        next_level = `MLIC_LVL_OFF;
        next_nmi   = 1'b0;
        next_idx   = {IW{1'b0}};
        if (crystal_fail & ~active[3]) begin
            next_req = 1'b1;
            next_nmi = 1'b1;
        end else if (f_hi & ~active[3] & ~active[2]) begin
            next_req   = 1'b1;
            next_level = `MLIC_LVL_HIGH;
            next_idx   = idx_hi;
        end else if (f_med & ~(|active[3:1])) begin
            next_req   = 1'b1;
            next_level = `MLIC_LVL_MED;
            next_idx   = idx_med;
        end else if (f_lo & ~(|active)) begin
            next_req   = 1'b1;
            next_level = `MLIC_LVL_LOW;
            next_idx   = (ctrl[`MLIC_CTRL_RREN] & f_rr) ? idx_rr : idx_lo;
        end
        // levels at or below a running handler wait above
    end

    mlic_level_track u_track (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_en     (take),
        .set_onehot ({intr_nmi,
                      intr_level == `MLIC_LVL_HIGH,
                      intr_level == `MLIC_LVL_MED,
                      intr_level == `MLIC_LVL_LOW}),
        .ret        (cpu_reti),
        .active     (active)
    );

    // ----------------------------------------
    // cpu side
    // ----------------------------------------
    // request drops for the ack cycle so a stale winner cannot be taken twice
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_fetch  <= 1'b1;
            intr_req   <= 1'b0;
            intr_level <= `MLIC_LVL_OFF;
            intr_nmi   <= 1'b0;
            win_idx    <= {IW{1'b0}};
            pc_load    <= 1'b0;
            pc_value   <= {VW{1'b0}};
            src_ack    <= {N{1'b0}};
        end else begin
            pc_load <= 1'b0;
            src_ack <= {N{1'b0}};
            if (rst_fetch) begin
                // strap sampled on the first edge after release
                rst_fetch <= 1'b0;
                pc_load   <= 1'b1;
                pc_value  <= place(`MLIC_RESET_VEC, boot_reset_sel);
            end else if (take) begin
                intr_req <= 1'b0;
                pc_load  <= 1'b1;
                if (!intr_nmi)
                    src_ack[win_idx] <= 1'b1;
            end else begin
                intr_req   <= next_req;
                intr_level <= next_level;
                intr_nmi   <= next_nmi;
                win_idx    <= next_idx;
                if (next_nmi)
                    pc_value <= place(`MLIC_XTAL_FAIL_VEC, ctrl[`MLIC_CTRL_IVSEL]);
                else
                    pc_value <= place(src_vector(next_idx), ctrl[`MLIC_CTRL_IVSEL]);
            end
        end
    end

    // ----------------------------------------
    // round robin pointer
    // ----------------------------------------
    // a software write beats a low ack in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rr_ptr <= {IW{1'b0}};
        else if (wr_fire && paddr == `MLIC_OFF_RRPTR)
            rr_ptr <= pwdata[IW-1:0];
        else if (take && !intr_nmi && intr_level == `MLIC_LVL_LOW)
            rr_ptr <= win_idx;
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (paddr)
            `MLIC_OFF_ENABLE:   rd_data = en;
            `MLIC_OFF_LEVEL_LO: rd_data = lvl[31:0];
            `MLIC_OFF_LEVEL_HI: rd_data = lvl[63:32];
            `MLIC_OFF_CTRL:     rd_data = {24'h00_0000, ctrl};
            `MLIC_OFF_STATUS:   rd_data = status_word(active);
            `MLIC_OFF_RRPTR:    rd_data = {{(32-IW){1'b0}}, rr_ptr};
            `MLIC_OFF_PENDING:  rd_data = {{(32-N){1'b0}}, pend_lo | pend_med | pend_hi};
            default:            rd_err  = 1'b1;
        endcase
    end

    // one wait-free access phase: ready rises on the edge after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & rd_err;
            prdata  <= (setup_ph & ~pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en   <= 32'h0000_0000;
            lvl  <= 64'h0000_0000_0000_0000;
            ctrl <= `MLIC_CTRL_RST;
        end else if (wr_fire) begin
            case (paddr)
                `MLIC_OFF_ENABLE:   en         <= pwdata & {{(32-N){1'b0}}, {N{1'b1}}};
                `MLIC_OFF_LEVEL_LO: lvl[31:0]  <= pwdata;
                `MLIC_OFF_LEVEL_HI: lvl[63:32] <= pwdata;
                `MLIC_OFF_CTRL:     ctrl       <= pwdata[7:0];
                default:            ctrl       <= ctrl;
            endcase
        end
    end

endmodule

// ### testbench/mlic_top_chk.sv
// ----------------------------------------
// checker on the controller ports
// ----------------------------------------
module mlic_top_chk #(
    parameter N  = 26,
    parameter VW = 16
) (
    input wire          pclk,
    input wire          presetn,
    input wire [N-1:0]  irq_in,
    input wire          crystal_fail,
    input wire          cpu_ack,
    input wire          intr_req,
    input wire [1:0]    intr_level,
    input wire          intr_nmi,
    input wire          pc_load,
    input wire [VW-1:0] pc_value,
    input wire [N-1:0]  src_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ack_loads_pc: assert property (cpu_ack && intr_req |=> pc_load)
        else $error("no pc load after ack");
    a_ack_drops_req: assert property (cpu_ack && intr_req |=> !intr_req)
        else $error("offer stays up after ack");
    a_grant_onehot: assert property (src_ack != '0 |-> $onehot(src_ack) && pc_load)
        else $error("grant not one-hot with pc load");
    a_vector_kept: assert property (cpu_ack && intr_req |=> pc_value == $past(pc_value))
        else $error("loaded vector differs from offer");
    a_nmi_vector: assert property (intr_req && intr_nmi |-> pc_value == 'h2)
        else $error("nmi offered at wrong vector");
    // a source grant on the nmi path would ack a peripheral that never asked
    a_nmi_no_grant: assert property (pc_load && $past(intr_nmi) && $past(cpu_ack) |-> src_ack == '0)
        else $error("source granted on nmi");
    a_quiet_no_req: assert property (irq_in == '0 && !crystal_fail |=> !intr_req)
        else $error("offer without any request");
    a_grant_from_req: assert property (src_ack != '0 |-> ($past(irq_in) & src_ack) == src_ack)
        else $error("grant to idle source");

    c_nmi: cover property (intr_req && intr_nmi);
    c_high: cover property (intr_req && intr_level == 2'h3);
    c_med: cover property (intr_req && intr_level == 2'h2);
endmodule

bind mlic_top mlic_top_chk #(.N(N), .VW(VW)) u_chk (
    .pclk(pclk), .presetn(presetn), .irq_in(irq_in), .crystal_fail(crystal_fail),
    .cpu_ack(cpu_ack), .intr_req(intr_req), .intr_level(intr_level), .intr_nmi(intr_nmi),
    .pc_load(pc_load), .pc_value(pc_value), .src_ack(src_ack)
);

// ### testbench/mlic_cpu_model.sv
// ----------------------------------------
// cpu core: takes offers, returns on command
// ----------------------------------------
module mlic_cpu_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ack_en,
    input  wire logic reti_cmd,
    input  wire logic intr_req,
    output logic      cpu_ack,
    output logic      cpu_reti
);
    timeunit 1ns;
    timeprecision 1ns;
    // ack drops after one taken edge so one offer is never taken twice
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            cpu_reti <= 1'b0;
        end else begin
            cpu_ack <= ack_en & intr_req & ~cpu_ack;
            cpu_reti <= reti_cmd;
        end
    end
endmodule

// ### testbench/multilevel_interrupt_controller_test.sv
// ----------------------------------------
// controller bench
// ----------------------------------------
module multilevel_interrupt_controller_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] BOOT = 16'h0400;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic        crystal_fail, boot_reset_sel, ack_en, reti_cmd, cpu_ack, cpu_reti;
    logic        intr_req, intr_nmi, pc_load;
    logic [1:0]  intr_level;
    logic [7:0]  paddr;
    logic [15:0] pc_value;
    logic [25:0] irq_in, src_ack;
    logic [31:0] pwdata, prdata, rd;
    int          err_total, checks;
    logic [15:0] vec_tab [26] = '{16'h0004, 16'h0006, 16'h0008, 16'h000c, 16'h0014,
        16'h0016, 16'h0018, 16'h001c, 16'h0028, 16'h0030, 16'h0032, 16'h003e,
        16'h0046, 16'h0048, 16'h004a, 16'h004e, 16'h0052, 16'h0058, 16'h0060,
        16'h0064, 16'h0074, 16'h008a, 16'h0096, 16'h009a, 16'h00a0, 16'h00a2};
    logic [7:0]  stat_tab [5] = '{8'h87, 8'h07, 8'h03, 8'h01, 8'h00};

    mlic_top #(.BOOT_BASE(BOOT)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_in(irq_in), .crystal_fail(crystal_fail), .boot_reset_sel(boot_reset_sel),
        .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .intr_req(intr_req), .intr_level(intr_level),
        .intr_nmi(intr_nmi), .pc_load(pc_load), .pc_value(pc_value), .src_ack(src_ack)
    );
    mlic_cpu_model cpu (
        .pclk(pclk), .presetn(presetn), .ack_en(ack_en), .reti_cmd(reti_cmd),
        .intr_req(intr_req), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // a missed pulse is counted here instead of hanging the bench
    task automatic wait_pc;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pc_load !== 1'b1 && n < 40);
        if (pc_load !== 1'b1) begin
            err_total++;
            $display("[FAIL] t=%0t no program counter load", $time);
        end
    endtask

    task automatic ret;
        @(posedge pclk);
        reti_cmd <= 1'b1;
        @(posedge pclk);
        reti_cmd <= 1'b0;
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        print_verdict;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, crystal_fail, boot_reset_sel, reti_cmd} = '0;
        {paddr, pwdata, irq_in} = '0;
        ack_en = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_pc;
        check(pc_value, 16'h0000);
        apb(1'b1, 8'h04, 32'h5555_5555);
        apb(1'b1, 8'h08, 32'h0005_5555);
        apb(1'b1, 8'h0c, 32'h0000_0007);
        irq_in <= 26'h1;
        repeat (4) @(posedge pclk);
        check(intr_req, 1'b0);
        apb(1'b1, 8'h00, 32'h03ff_ffff);
        for (int k = 0; k < 26; k++) begin
            irq_in <= 26'h1 << k;
            wait_pc;
            check(pc_value, vec_tab[k]);
            check(src_ack, 26'h1 << k);
            check(intr_level, 2'h1);
            irq_in <= '0;
            ret;
            apb(1'b0, 8'h10, '0);
            check(rd, 32'h0);
        end
        // low pair, then medium and high stacked over the low handler
        irq_in <= 26'h28;
        wait_pc;
        check(pc_value, 16'h000c);
        irq_in <= 26'h20;
        repeat (5) @(posedge pclk);
        check(intr_req, 1'b0);
        apb(1'b1, 8'h08, 32'h0005_7655);
        irq_in <= 26'h100020;
        wait_pc;
        check(pc_value, 16'h0074);
        check(intr_level, 2'h2);
        irq_in <= 26'h400020;
        wait_pc;
        check(pc_value, 16'h0096);
        check(intr_level, 2'h3);
        irq_in <= 26'h20;
        apb(1'b1, 8'h0c, 32'h0);
        crystal_fail <= 1'b1;
        wait_pc;
        check(pc_value, 16'h0002);
        check(src_ack, 26'h0);
        check(intr_nmi, 1'b1);
        crystal_fail <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'h10, '0);
            check(rd, stat_tab[i]);
            if (i < 4)
                ret;
        end
        // second pass moves vectors into the boot section and reloads the pointer
        apb(1'b1, 8'h0c, 32'h0000_0041);
        for (int i = 0; i < 2; i++) begin
            irq_in <= 26'h28;
            wait_pc;
            check(pc_value, (i == 0) ? 16'h0016 : BOOT + 16'h0016);
            irq_in <= '0;
            ret;
            apb(1'b0, 8'h14, '0);
            check(rd, 32'h5);
            apb(1'b1, 8'h0c, 32'h0000_00c1);
            apb(1'b1, 8'h14, 32'h0000_0004);
        end
        apb(1'b0, 8'h1c, '0);
        check(rerr, 1'b1);
        check(rd, 32'h0);
        boot_reset_sel <= 1'b1;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_pc;
        check(pc_value, BOOT);
        print_verdict;
    end
endmodule
